/* include/clk_cfg_pkg.sv */
// constants and types for the run-mode clock configuration block
//
// Contract
// - With the pwm divider enabled, the pwm timing clock comes from the predivider output.
// - Divisor codes 0..4 divide by 2,4,8,16,32, codes 5..7 by 64, and the field resets to 7.
// - The predivider divides by powers of two only, its edges aligned to system clock edges.
// - The pll power-down bit drives the pll power-down input directly, one meaning powered down.
// - The pll power-down bit resets to one, so the pll stays off until software clears it.
// - With bypass set the system clock comes from the oscillator source; bypass resets to one.
// - With bypass clear the system clock is the pll output divided by the system divisor, floored at minimum_system_divisor_in.
// - Bits 16:14 and 10 read as zero, bit 12 reads as one, and software preserves them.
// - The system divider is always used while the pll is the selected source.
// - Source codes 0..3 pick main, internal (reset), internal divided by four, and 30 kHz.
package clk_cfg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] CFG_OFFSET  = 12'h060;
  localparam logic [31:0] CFG_RESET   = 32'h078E_3AD1;
  localparam logic [31:0] CFG_WR_MASK = 32'h0FDE_2BF3;
  localparam logic [31:0] CFG_RO_ONES = 32'h0000_1000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // pwm predivider
  // ****************************************
  localparam int          PWM_CNT_W     = 6;
  localparam logic [2:0]  PWM_SEL_RESET = 3'h7;
  localparam logic [2:0]  PWM_SEL_MAX   = 3'h5;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    OSC_MAIN          = 2'b00,
    OSC_INTERNAL      = 2'b01,
    OSC_INTERNAL_DIV4 = 2'b10,
    OSC_LOW_30K       = 2'b11
  } osc_src_t;

  typedef struct packed {
    logic [3:0] rsv31_28;
    logic       auto_clock_gating;
    logic [3:0] system_clock_divisor;
    logic       system_divider_enable;
    logic       rsv21;
    logic       pwm_divider_enable;
    logic [2:0] pwm_divisor_select;
    logic [2:0] rsv16_14;
    logic       pll_power_down;
    logic       rsv12;
    logic       pll_bypass;
    logic       rsv10;
    logic [3:0] crystal_value;
    osc_src_t   oscillator_source_select;
    logic [1:0] rsv3_2;
    logic       internal_oscillator_disable;
    logic       main_oscillator_disable;
  } cfg_t;

  typedef struct packed {
    logic       pll_power_down;
    logic       sysclk_from_osc;
    logic       sys_div_active;
    logic [3:0] sys_div_value;
    osc_src_t   osc_source;
    logic       main_osc_disable;
    logic       int_osc_disable;
    logic [3:0] crystal_value;
    logic       auto_clock_gating;
  } clk_ctrl_t;

  typedef struct packed {
    cfg_t              cfg;
    logic              aw_pend;
    logic              w_pend;
    logic [ADDR_W-1:0] waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } slv_state_t;

endpackage : clk_cfg_pkg

/* rtl/pwm_predivider.sv */
// power-of-two pwm clock predivider producing a one-cycle tick
`timescale 1ns/100ps
`default_nettype none
module pwm_predivider #(
  parameter int CNT_W = clk_cfg_pkg::PWM_CNT_W
) (
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  input  wire logic       div_enable_in,
  input  wire logic [2:0] div_select_in,
  output logic            tick_out,
  output logic            div_active_out
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             en_act;
    logic [2:0]       sel_act;
    logic             tick;
  } pwm_state_t;

  pwm_state_t st_r;
  pwm_state_t st_nxt;

  // codes above five clamp to 64
  function automatic logic [CNT_W-1:0] sel_mask(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > clk_cfg_pkg::PWM_SEL_MAX) ? clk_cfg_pkg::PWM_SEL_MAX : sel;
    return CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << (s + 3'h1)) - 1);
  endfunction : sel_mask

  // ****************************************
  // divider
  // ****************************************
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.cnt = st_r.cnt + 1'b1;
    if (st_nxt.cnt == '0)
    begin
      st_nxt.en_act  = div_enable_in;
      st_nxt.sel_act = div_select_in;
    end
    if (st_nxt.en_act)
      st_nxt.tick = (st_nxt.cnt & sel_mask(st_nxt.sel_act)) == '0;
    else
      st_nxt.tick = 1'b1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      st_r.cnt     <= '0;
      st_r.en_act  <= 1'b0;
      st_r.sel_act <= clk_cfg_pkg::PWM_SEL_RESET;
      st_r.tick    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // tick is the pwm timing clock
  assign tick_out       = st_r.tick;
  assign div_active_out = st_r.en_act;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_div64_tick;
    tick_out && st_r.en_act && st_r.sel_act >= clk_cfg_pkg::PWM_SEL_MAX;
  endsequence

  sequence s_div2_tick;
    tick_out && st_r.en_act && st_r.sel_act == 3'h0;
  endsequence

  a_tick_aligned: assert property (
    tick_out && st_r.en_act |-> (st_r.cnt & sel_mask(st_r.sel_act)) == '0)
    else $error("pwm tick off its power-of-two phase");
  a_undivided_clk: assert property (
    !st_r.en_act |-> tick_out)
    else $error("pwm tick missing while divider off");
  a_load_at_wrap: assert property (
    $changed(st_r.sel_act) || $changed(st_r.en_act) |-> st_r.cnt == '0)
    else $error("pwm divisor changed mid period");
  a_div64_gap: assert property (
    s_div64_tick |=> !tick_out [*8])
    else $error("divide by 64 ticked too early");
  a_div2_period: assert property (
    s_div2_tick |=> !tick_out ##1 tick_out)
    else $error("divide by 2 period wrong");

endmodule : pwm_predivider
`default_nettype wire

/* rtl/pwm_clock_and_pll_select.sv */
// run-mode clock configuration register with axi4-lite access
`timescale 1ns/100ps
`default_nettype none
module pwm_clock_and_pll_select (
  input  wire logic                           ref_clk_in,
  input  wire logic                           srst_in,
  // axi4-lite slave
  input  wire logic [clk_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [clk_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // clock tree side
  input  wire logic [3:0]                     minimum_system_divisor_in,
  output clk_cfg_pkg::clk_ctrl_t              clk_ctrl_out,
  output logic                                pwm_tick_out,
  output logic                                pwm_from_divider_out
);

  clk_cfg_pkg::slv_state_t st_r;
  clk_cfg_pkg::slv_state_t st_nxt;

  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic [3:0]  wstrb_cur;
  logic [31:0] lane_mask;
  logic [31:0] cfg_merged;

  // ****************************************
  // handshakes
  // ****************************************
  assign s_axi_awready = !st_r.aw_pend && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_pend && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  assign wstrb_cur = w_hs ? s_axi_wstrb : st_r.wstrb;

  // ****************************************
  // byte lane write mask
  // ****************************************
  for (genvar lane = 0; lane < 4; lane++)
  begin : g_lane
    assign lane_mask[lane*8 +: 8] = {8{wstrb_cur[lane]}} & clk_cfg_pkg::CFG_WR_MASK[lane*8 +: 8];
  end

  // read-only bits forced to fixed values
  always_comb
  begin
    logic [31:0] wd;
    wd         = w_hs ? s_axi_wdata : st_r.wdata;
    cfg_merged = (32'(st_r.cfg) & ~lane_mask) | (wd & lane_mask);
    cfg_merged = (cfg_merged & clk_cfg_pkg::CFG_WR_MASK) | clk_cfg_pkg::CFG_RO_ONES;
  end

  // ****************************************
  // register slave
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    if (aw_hs)
    begin
      st_nxt.aw_pend = 1'b1;
      st_nxt.waddr   = s_axi_awaddr;
    end
    if (w_hs)
    begin
      st_nxt.w_pend = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
    end
    // write commits once address and data are both in
    if (st_nxt.aw_pend && st_nxt.w_pend)
    begin
      st_nxt.aw_pend = 1'b0;
      st_nxt.w_pend  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      if (st_nxt.waddr[clk_cfg_pkg::ADDR_W-1:2] == clk_cfg_pkg::CFG_OFFSET[11:2])
      begin
        st_nxt.cfg   = clk_cfg_pkg::cfg_t'(cfg_merged);
        st_nxt.bresp = clk_cfg_pkg::RESP_OKAY;
      end
      else
        st_nxt.bresp = clk_cfg_pkg::RESP_SLVERR;
    end
    if (ar_hs)
    begin
      st_nxt.rvalid = 1'b1;
      if (s_axi_araddr[clk_cfg_pkg::ADDR_W-1:2] == clk_cfg_pkg::CFG_OFFSET[11:2])
      begin
        st_nxt.rdata = 32'(st_r.cfg);
        st_nxt.rresp = clk_cfg_pkg::RESP_OKAY;
      end
      else
      begin
        st_nxt.rdata = '0;
        st_nxt.rresp = clk_cfg_pkg::RESP_SLVERR;
      end
    end
  end

  // power-down and bypass come up set
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      st_r.cfg     <= clk_cfg_pkg::cfg_t'(clk_cfg_pkg::CFG_RESET);
      st_r.aw_pend <= 1'b0;
      st_r.w_pend  <= 1'b0;
      st_r.waddr   <= '0;
      st_r.wdata   <= '0;
      st_r.wstrb   <= '0;
      st_r.bvalid  <= 1'b0;
      st_r.bresp   <= clk_cfg_pkg::RESP_OKAY;
      st_r.rvalid  <= 1'b0;
      st_r.rdata   <= '0;
      st_r.rresp   <= clk_cfg_pkg::RESP_OKAY;
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata  = st_r.rdata;
  assign s_axi_rresp  = st_r.rresp;

  // ****************************************
  // clock tree controls
  // ****************************************
  always_comb
  begin
    // power-down bit straight to the pll
    clk_ctrl_out.pll_power_down    = st_r.cfg.pll_power_down;
    clk_ctrl_out.sysclk_from_osc   = st_r.cfg.pll_bypass;
    clk_ctrl_out.sys_div_active    = !st_r.cfg.pll_bypass || st_r.cfg.system_divider_enable;
    // pll path divisor, floored at minimum
    if (!st_r.cfg.pll_bypass && st_r.cfg.system_clock_divisor < minimum_system_divisor_in)
      clk_ctrl_out.sys_div_value = minimum_system_divisor_in;
    else
      clk_ctrl_out.sys_div_value = st_r.cfg.system_clock_divisor;
    // oscillator source code passed through unchanged as the enum
    clk_ctrl_out.osc_source        = st_r.cfg.oscillator_source_select;
    clk_ctrl_out.main_osc_disable  = st_r.cfg.main_oscillator_disable;
    clk_ctrl_out.int_osc_disable   = st_r.cfg.internal_oscillator_disable;
    clk_ctrl_out.crystal_value     = st_r.cfg.crystal_value;
    clk_ctrl_out.auto_clock_gating = st_r.cfg.auto_clock_gating;
  end

  // ****************************************
  // pwm predivider
  // ****************************************
  // pwm clock source select
  pwm_predivider #(
    .CNT_W (clk_cfg_pkg::PWM_CNT_W)
  ) u_pwm_predivider (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .div_enable_in  (st_r.cfg.pwm_divider_enable),
    .div_select_in  (st_r.cfg.pwm_divisor_select),
    .tick_out       (pwm_tick_out),
    .div_active_out (pwm_from_divider_out)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  // register views for the checks
  clk_cfg_pkg::cfg_t rd_view;
  clk_cfg_pkg::cfg_t wr_view;
  logic [31:0]       cfg_word;
  logic              aw_mapped;

  assign rd_view   = clk_cfg_pkg::cfg_t'(s_axi_rdata);
  assign wr_view   = clk_cfg_pkg::cfg_t'(s_axi_wdata);
  assign cfg_word  = st_r.cfg;
  assign aw_mapped = s_axi_awaddr[clk_cfg_pkg::ADDR_W-1:2] == clk_cfg_pkg::CFG_OFFSET[11:2];

  sequence s_write_both;
    aw_hs && w_hs;
  endsequence

  sequence s_write_answer;
    s_axi_bvalid [*1] ##0 !s_axi_awready && !s_axi_wready;
  endsequence

  sequence s_full_write;
    s_write_both ##0 aw_mapped && (&s_axi_wstrb);
  endsequence

  sequence s_stray_write;
    s_write_both ##0 !aw_mapped;
  endsequence

  a_reset_state: assert property (
    $past(srst_in) |-> clk_ctrl_out.pll_power_down && clk_ctrl_out.sysclk_from_osc
      && clk_ctrl_out.osc_source == clk_cfg_pkg::OSC_INTERNAL && !pwm_from_divider_out)
    else $error("clock controls wrong after reset");
  a_cfg_by_write: assert property (
    $changed(clk_ctrl_out.pll_power_down) |-> $rose(s_axi_bvalid)
      && s_axi_bresp == clk_cfg_pkg::RESP_OKAY)
    else $error("pll power-down moved without a write");
  a_ro_readback: assert property (
    s_axi_rvalid && s_axi_rresp == clk_cfg_pkg::RESP_OKAY
      |-> rd_view.rsv16_14 == 3'h0 && rd_view.rsv12 && !rd_view.rsv10)
    else $error("read-only bits read back wrong");
  a_pll_path_div: assert property (
    !clk_ctrl_out.sysclk_from_osc |-> clk_ctrl_out.sys_div_active
      && clk_ctrl_out.sys_div_value >= minimum_system_divisor_in)
    else $error("pll path without system divider");
  a_osc_path_div: assert property (
    clk_ctrl_out.sysclk_from_osc && !st_r.cfg.system_divider_enable
      |-> !clk_ctrl_out.sys_div_active)
    else $error("oscillator path divided while divider off");
  a_write_answer: assert property (
    s_write_both |=> s_write_answer)
    else $error("write response not one cycle after address and data");
  a_read_answer: assert property (
    ar_hs |=> s_axi_rvalid
      && (s_axi_rresp != clk_cfg_pkg::RESP_OKAY || s_axi_rdata == $past(cfg_word)))
    else $error("read response missing or stale");
  a_pwm_follow: assert property (
    $rose(pwm_from_divider_out) |-> $past(st_r.cfg.pwm_divider_enable))
    else $error("pwm divider used without its enable");

  // ****************************************
  // write effects
  // ****************************************
  a_pd_by_write: assert property (
    s_full_write |=> clk_ctrl_out.pll_power_down == $past(wr_view.pll_power_down))
    else $error("pll power-down does not follow the written bit");
  a_bypass_by_write: assert property (
    s_full_write |=> clk_ctrl_out.sysclk_from_osc == $past(wr_view.pll_bypass))
    else $error("bypass does not follow the written bit");
  a_pwm_sel_write: assert property (
    s_full_write |=> st_r.cfg.pwm_divisor_select == $past(wr_view.pwm_divisor_select))
    else $error("pwm divisor select not stored");
  a_pwm_en_write: assert property (
    s_full_write |=> st_r.cfg.pwm_divider_enable == $past(wr_view.pwm_divider_enable))
    else $error("pwm divider enable not stored");
  a_osc_by_write: assert property (
    s_full_write |=> clk_ctrl_out.osc_source == $past(wr_view.oscillator_source_select))
    else $error("oscillator source does not follow the written code");
  a_system_clock_divisor_by_write: assert property (
    s_full_write |=> st_r.cfg.system_clock_divisor == $past(wr_view.system_clock_divisor))
    else $error("system divisor not stored");
  a_stray_write: assert property (
    s_stray_write |=> $stable(cfg_word) && s_axi_bresp == clk_cfg_pkg::RESP_SLVERR)
    else $error("unmapped write changed the register");

  // ****************************************
  // register and divisor invariants
  // ****************************************
  a_ro_bits_fixed: assert property (
    st_r.cfg.rsv16_14 == 3'h0 && st_r.cfg.rsv12 && !st_r.cfg.rsv10)
    else $error("read-only bits of the register moved");
  a_cfg_reset: assert property (
    $past(srst_in) |-> cfg_word == clk_cfg_pkg::CFG_RESET)
    else $error("register not at its reset value");
  a_sel_reset: assert property (
    $past(srst_in) |-> st_r.cfg.pwm_divisor_select == clk_cfg_pkg::PWM_SEL_RESET
      && !st_r.cfg.pwm_divider_enable)
    else $error("pwm divisor select wrong after reset");
  a_div_floor: assert property (
    !clk_ctrl_out.sysclk_from_osc
      && st_r.cfg.system_clock_divisor < minimum_system_divisor_in
      |-> clk_ctrl_out.sys_div_value == minimum_system_divisor_in)
    else $error("system divisor below the floor on the pll path");
  a_div_passed: assert property (
    clk_ctrl_out.sysclk_from_osc
      || st_r.cfg.system_clock_divisor >= minimum_system_divisor_in
      |-> clk_ctrl_out.sys_div_value == st_r.cfg.system_clock_divisor)
    else $error("system divisor altered without cause");
  a_tick_undivided: assert property (
    !pwm_from_divider_out |-> pwm_tick_out)
    else $error("pwm tick missing with the divider off");
  a_ready_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response waits");
  a_rd_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while read data waits");

endmodule : pwm_clock_and_pll_select
`default_nettype wire

/* test/clk_far_side_model.sv */
// far-side model: pll, oscillator mux and pwm timing consumer
`timescale 1ns/100ps
`default_nettype none
module clk_far_side_model (
  input  wire logic                   ref_clk_in,
  input  wire logic                   srst_in,
  input  wire clk_cfg_pkg::clk_ctrl_t clk_ctrl_in,
  input  wire logic                   pwm_tick_in,
  output logic                        pll_running_out,
  output logic                        sysclk_from_pll_out,
  output logic [31:0]                 pwm_ticks_out
);
  assign pll_running_out = !clk_ctrl_in.pll_power_down;
  assign sysclk_from_pll_out = !clk_ctrl_in.sysclk_from_osc && clk_ctrl_in.sys_div_active;
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      pwm_ticks_out <= 32'h0000_0000;
    else if (pwm_tick_in)
      pwm_ticks_out <= pwm_ticks_out + 32'h0000_0001;
  end
endmodule : clk_far_side_model
`default_nettype wire

/* test/pwm_clock_and_pll_select_tb.sv */
// self-checking bench for the run-mode clock configuration block
`timescale 1ns/100ps
`default_nettype none
module pwm_clock_and_pll_select_tb;
  // ****************************************
  // signals
  // ****************************************
  logic                   clk, srst, tick, from_div, pll_on, from_pll;
  logic [11:0]            awaddr, araddr;
  logic [31:0]            wdata, rdata, ticks;
  logic [3:0]             wstrb, min_div;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready;
  logic [1:0]             bresp, rresp;
  clk_cfg_pkg::clk_ctrl_t ctrl;
  int                     fails, checks_done;
  localparam logic [11:0] A = clk_cfg_pkg::CFG_OFFSET;

  pwm_clock_and_pll_select u_dut (
    .ref_clk_in(clk), .srst_in(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .minimum_system_divisor_in(min_div), .clk_ctrl_out(ctrl),
    .pwm_tick_out(tick), .pwm_from_divider_out(from_div)
  );

  clk_far_side_model u_far (
    .ref_clk_in(clk), .srst_in(srst), .clk_ctrl_in(ctrl), .pwm_tick_in(tick),
    .pll_running_out(pll_on), .sysclk_from_pll_out(from_pll), .pwm_ticks_out(ticks)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, done;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    done = 1'h0;
    while (!done)
    begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_hs)
        awvalid <= 1'h0;
      if (w_hs)
        wvalid <= 1'h0;
    end
    bready <= 1'h0;
    check(r, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_hs, done;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    done = 1'h0;
    while (!done)
    begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hs)
        arvalid <= 1'h0;
    end
    rready <= 1'h0;
    check(d, ed);
    check(r, er);
  endtask : axi_rd

  // spacing of ticks over 128 cycles once the divider change has landed
  task automatic pwm_measure(input int div);
    int last;
    logic [31:0] start;
    repeat (130) @(posedge clk);
    @(negedge clk);
    start = ticks;
    last = -1;
    for (int i = 0; i < 128; i++)
    begin
      @(negedge clk);
      if (tick === 1'h1)
      begin
        if (last >= 0)
          check(i - last, div);
        last = i;
      end
    end
    check(ticks - start, 128 / div);
  endtask : pwm_measure

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    axi_rd(A, clk_cfg_pkg::CFG_RESET, clk_cfg_pkg::RESP_OKAY);
    @(negedge clk);
    check(ctrl.pll_power_down, 1'h1);
    check(pll_on, 1'h0);
    check(ctrl.sysclk_from_osc, 1'h1);
    check(ctrl.osc_source, clk_cfg_pkg::OSC_INTERNAL);
    check(from_div, 1'h0);
    pwm_measure(1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_fields();
    clk_cfg_pkg::cfg_t c;
    axi_wr(A, 32'hFFFF_FFFF, clk_cfg_pkg::RESP_OKAY);
    axi_rd(A, clk_cfg_pkg::CFG_WR_MASK | clk_cfg_pkg::CFG_RO_ONES,
           clk_cfg_pkg::RESP_OKAY);
    @(negedge clk);
    check(ctrl, 32'h0000_FFFF);
    @(posedge clk);
    min_div <= 4'h5;
    axi_wr(A, 32'h0000_0000, clk_cfg_pkg::RESP_OKAY);
    axi_rd(A, clk_cfg_pkg::CFG_RO_ONES, clk_cfg_pkg::RESP_OKAY);
    @(negedge clk);
    check(pll_on, 1'h1);
    check(from_pll, 1'h1);
    check(ctrl.sys_div_active, 1'h1);
    check(ctrl.sys_div_value, 4'h5);
    c = clk_cfg_pkg::CFG_RESET;
    c.system_clock_divisor = 4'h2;
    axi_wr(A, c, clk_cfg_pkg::RESP_OKAY);
    @(negedge clk);
    check(ctrl.sys_div_value, 4'h2);
    check(from_pll, 1'h0);
    for (int k = 0; k < 4; k++)
    begin
      c.oscillator_source_select = clk_cfg_pkg::osc_src_t'(k[1:0]);
      axi_wr(A, c, clk_cfg_pkg::RESP_OKAY);
      @(negedge clk);
      check(ctrl.osc_source, k[1:0]);
    end
    $display("field test done");
  endtask : t_fields

  task automatic t_pwm();
    clk_cfg_pkg::cfg_t c;
    c = clk_cfg_pkg::CFG_RESET;
    c.pwm_divider_enable = 1'h1;
    for (int k = 0; k < 8; k++)
    begin
      c.pwm_divisor_select = k[2:0];
      axi_wr(A, c, clk_cfg_pkg::RESP_OKAY);
      pwm_measure(1 << ((k > 4 ? 5 : k) + 1));
      check(from_div, 1'h1);
    end
    c.pwm_divider_enable = 1'h0;
    axi_wr(A, c, clk_cfg_pkg::RESP_OKAY);
    pwm_measure(1);
    check(from_div, 1'h0);
    $display("pwm test done");
  endtask : t_pwm

  task automatic t_unmapped();
    axi_wr(A + 12'h004, 32'h0000_0000, clk_cfg_pkg::RESP_SLVERR);
    axi_rd(A + 12'h004, 32'h0000_0000, clk_cfg_pkg::RESP_SLVERR);
    axi_rd(A, clk_cfg_pkg::CFG_RESET, clk_cfg_pkg::RESP_OKAY);
    $display("unmapped test done");
  endtask : t_unmapped

  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // ****************************************
  // clock, reset, sequence, watchdog
  // ****************************************
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    srst = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    min_div = 4'h0;
    fails = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    t_reset();
    t_fields();
    t_pwm();
    t_unmapped();
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule : pwm_clock_and_pll_select_tb
`default_nettype wire
